// ===== bdc_top.sv
/*
 Backup domain control: APB register bank for the always-on domain with
 crystal control, failure monitor, unlock, domain reset and supply flags.
 Assumes APB master with 32-bit data, supply and crystal inputs already
 synchronous to pclk, and presetn as the device reset.
*/
// Implementation choice: the APB interface to the registers.
// Function
// - Drive boost bit raises crystal drive current and swing.
// - Rate select resets to zero (1Hz); one selects 1.024kHz.
// - Rate select cannot change while the oscillator is on.
// - Writing one starts oscillator; zero ignored until domain reset.
// - Fault flagged only after 64 consecutive missing swings.
// - Monitor enable clears only by domain reset.
// - Domain registers need unlock, except the three supply flags.
// - Unlock bit clears only on device reset.
// - Writing one to reset bit while protect_open is high resets domain for one cycle.
// - Reset request dropped when the same write starts osc or monitor.
// - Domain reset clears boost, rate, osc, monitor and stable flag.
// - Absent flag set when no backup supply at reset exit; W1C.
// - Stable flag set once crystal is running; domain reset clears.
// - Fault flag set on failure; W1C or domain reset clears.
// - Brownout flag set by detector on backup power; W1C.
// - Insert flag updates only at startup; W1C.
// - Supply insertion during main power leaves insert flag alone.
// - Two retained 8-bit scratch registers at offsets two and three.
// - Main brownout blocks all writes and the backup brownout flag.
`timescale 1ns/1ns
`default_nettype none
module bdc_top
   import bdc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic protect_open,
   input wire logic main_brownout,
   input wire logic backup_supply_pin,
   input wire logic on_backup_power,
   input wire logic supply_brownout_detector,
   input wire logic crystal_swing,
   output logic crystal_osc_on,
   output logic crystal_drive_boost,
   output logic tick_rate_select,
   output logic crystal_monitor_on,
   output logic domain_access_unlock,
   output logic domain_reset_pulse
);
   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   logic wr_acc;
   logic [3:0] idx;
   logic mapped;
   logic wr_ok;
   logic lane0;
   logic [7:0] wb;
   logic gated_ok;
   logic ctl_wr;
   logic flg_wr;
   logic s0_wr;
   logic s1_wr;

   assign idx = paddr[5:2];
   assign mapped = (paddr[31:BDC_ADDR_W] == '0) && (paddr[1:0] == 2'b00)
      && (idx <= BDC_IDX_SCRATCH1);
   assign wr_acc = psel && penable && pwrite;
   assign lane0 = pstrb[0];
   assign wb = pwdata[7:0];
   assign wr_ok = wr_acc && mapped && lane0 && !main_brownout;
   assign gated_ok = domain_access_unlock;
   assign ctl_wr = wr_ok && (idx == BDC_IDX_CONTROL);
   assign flg_wr = wr_ok && (idx == BDC_IDX_FLAGS);
   assign s0_wr = wr_ok && gated_ok && (idx == BDC_IDX_SCRATCH0);
   assign s1_wr = wr_ok && gated_ok && (idx == BDC_IDX_SCRATCH1);

   // ---------------------------------------------------------------
   // Domain reset request
   // ---------------------------------------------------------------
   logic drst_req;
   logic drst_r;

   assign drst_req = ctl_wr && gated_ok && wb[BDC_CTL_DRST]
      && protect_open
      && !wb[BDC_CTL_OSC] && !wb[BDC_CTL_MON];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drst_r <= 1'b0;
      end else begin
         drst_r <= drst_req;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         domain_reset_pulse <= 1'b0;
      end else begin
         domain_reset_pulse <= drst_req;
      end
   end

   // ---------------------------------------------------------------
   // Control register
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         domain_access_unlock <= 1'b0;
      end else if (ctl_wr && wb[BDC_CTL_UNLOCK]) begin
         domain_access_unlock <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crystal_osc_on <= 1'b0;
         crystal_monitor_on <= 1'b0;
         crystal_drive_boost <= 1'b0;
         tick_rate_select <= 1'b0;
      end else if (drst_r) begin
         crystal_osc_on <= 1'b0;
         crystal_monitor_on <= 1'b0;
         crystal_drive_boost <= 1'b0;
         tick_rate_select <= 1'b0;
      end else if (ctl_wr && gated_ok) begin
         crystal_drive_boost <= wb[BDC_CTL_BOOST];
         if (!crystal_osc_on) begin
            tick_rate_select <= wb[BDC_CTL_RATE];
         end
         if (wb[BDC_CTL_OSC]) begin
            crystal_osc_on <= 1'b1;
         end
         if (wb[BDC_CTL_MON]) begin
            crystal_monitor_on <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Crystal stable and failure monitor
   // ---------------------------------------------------------------
   logic [BDC_MISS_W-1:0] miss_cnt_r;
   logic [4:0] good_cnt_r;
   logic stable_r;
   logic fault_set;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         miss_cnt_r <= '0;
      end else if (drst_r || !crystal_monitor_on || crystal_swing) begin
         miss_cnt_r <= '0;
      end else if (miss_cnt_r != BDC_MISS_W'(BDC_MISS_SWINGS)) begin
         miss_cnt_r <= miss_cnt_r + 1'b1;
      end
   end
   assign fault_set = crystal_monitor_on && !crystal_swing
      && (miss_cnt_r == BDC_MISS_W'(BDC_MISS_SWINGS - 1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         good_cnt_r <= '0;
         stable_r <= 1'b0;
      end else if (drst_r) begin
         good_cnt_r <= '0;
         stable_r <= 1'b0;
      end else if (crystal_osc_on && crystal_swing && !stable_r) begin
         if (good_cnt_r == 5'(BDC_STABLE_SWINGS - 1)) begin
            stable_r <= 1'b1;
         end else begin
            good_cnt_r <= good_cnt_r + 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Supply and fault flags
   // ---------------------------------------------------------------
   logic started_r;
   logic absent_r;
   logic insert_r;
   logic brown_r;
   logic fault_r;
   logic brown_set;
   logic boot_pulse;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         started_r <= 1'b0;
      end else begin
         started_r <= 1'b1;
      end
   end
   assign boot_pulse = !started_r;
   assign brown_set = supply_brownout_detector && on_backup_power
      && !main_brownout;

   bdc_sticky u_absent (
      .pclk(pclk), .presetn(presetn),
      .set_i(boot_pulse && !backup_supply_pin),
      .clr_i(flg_wr && wb[BDC_FLG_ABSENT]),
      .flag_r(absent_r)
   );
   bdc_sticky u_insert (
      .pclk(pclk), .presetn(presetn),
      .set_i(boot_pulse && backup_supply_pin),
      .clr_i(flg_wr && wb[BDC_FLG_INSERT]),
      .flag_r(insert_r)
   );
   bdc_sticky u_brown (
      .pclk(pclk), .presetn(presetn),
      .set_i(brown_set),
      .clr_i(flg_wr && wb[BDC_FLG_BROWN]),
      .flag_r(brown_r)
   );
   bdc_sticky u_fault (
      .pclk(pclk), .presetn(presetn),
      .set_i(fault_set),
      .clr_i(drst_r || (flg_wr && gated_ok && wb[BDC_FLG_FAULT])),
      .flag_r(fault_r)
   );

   // ---------------------------------------------------------------
   // Retained scratch
   // ---------------------------------------------------------------
   logic [7:0] scr0_r;
   logic [7:0] scr1_r;

   always_ff @(posedge pclk) begin
      if (s0_wr) begin
         scr0_r <= wb;
      end
      if (s1_wr) begin
         scr1_r <= wb;
      end
   end

   // ---------------------------------------------------------------
   // Read path
   // ---------------------------------------------------------------
   logic [7:0] rd_nxt;
   logic [7:0] ctl_view;
   logic [7:0] flg_view;

   assign ctl_view = {2'b00, crystal_drive_boost, tick_rate_select,
      crystal_osc_on, crystal_monitor_on, domain_access_unlock, 1'b0};

   always_comb begin
      flg_view = 8'h00;
      flg_view[BDC_FLG_ABSENT] = absent_r;
      flg_view[BDC_FLG_BROWN] = brown_r;
      flg_view[BDC_FLG_INSERT] = insert_r;
      if (gated_ok) begin
         flg_view[BDC_FLG_STABLE] = stable_r;
         flg_view[BDC_FLG_FAULT] = fault_r;
      end
   end

   always_comb begin
      rd_nxt = 8'h00;
      unique case (idx)
         BDC_IDX_CONTROL: rd_nxt = gated_ok ? ctl_view : 8'h00;
         BDC_IDX_FLAGS: rd_nxt = flg_view;
         BDC_IDX_SCRATCH0: rd_nxt = gated_ok ? scr0_r : 8'h00;
         BDC_IDX_SCRATCH1: rd_nxt = gated_ok ? scr1_r : 8'h00;
         default: rd_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= {24'h000000, (mapped ? rd_nxt : 8'h00)};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   drst_pulse_a: assert property (@(posedge pclk)
      disable iff (!presetn) drst_r |=> !drst_r)
      else $error("domain reset longer than one cycle");
   drst_clears_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      drst_r |=> !crystal_osc_on && !crystal_monitor_on && !stable_r
         && !tick_rate_select && !crystal_drive_boost)
      else $error("domain reset left settings");
   osc_sticky_a: assert property (@(posedge pclk)
      disable iff (!presetn) crystal_osc_on && !drst_r |=> crystal_osc_on)
      else $error("oscillator dropped without domain reset");
   mon_sticky_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      crystal_monitor_on && !drst_r |=> crystal_monitor_on)
      else $error("monitor dropped without domain reset");
   rate_hold_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      crystal_osc_on |=> $stable(tick_rate_select) || $past(drst_r))
      else $error("rate changed while oscillator on");
   unlock_hold_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      domain_access_unlock |=> domain_access_unlock)
      else $error("unlock cleared");
   drst_block_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      ctl_wr && (wb[BDC_CTL_OSC] || wb[BDC_CTL_MON]) |=> !drst_r)
      else $error("domain reset not blocked");
   fault_late_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      $rose(fault_r)
         |-> $past(miss_cnt_r) == BDC_MISS_W'(BDC_MISS_SWINGS - 1))
      else $error("fault flagged too early");
   lock_write_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      !domain_access_unlock && !drst_r |=> $stable(crystal_drive_boost))
      else $error("locked write took effect");
   insert_boot_a: assert property (@(posedge pclk)
      disable iff (!presetn) started_r |=> !$rose(insert_r))
      else $error("insert flag set after startup");
   absent_boot_a: assert property (@(posedge pclk)
      disable iff (!presetn) started_r |=> !$rose(absent_r))
      else $error("absent flag set after startup");
   fault_clear_a: assert property (@(posedge pclk)
      disable iff (!presetn) drst_r && !fault_set |=> !fault_r)
      else $error("fault flag kept through domain reset");
   brown_block_a: assert property (@(posedge pclk)
      disable iff (!presetn) main_brownout && !drst_r
      |=> $stable(domain_access_unlock) && $stable(crystal_osc_on)
         && !$rose(brown_r))
      else $error("write or flag taken in main brownout");
   lock_read_a: assert property (@(posedge pclk)
      disable iff (!presetn) !domain_access_unlock && psel && !penable
      && !pwrite && (idx != BDC_IDX_FLAGS) |=> prdata == 32'h00000000)
      else $error("locked register read not zero");
endmodule
`default_nettype wire

// ===== bdc_pkg.sv
/*
 Package for the backup domain control block: register offsets, field
 positions, reset values and timing counts.
 Assumes a 25 MHz APB clock and 32-bit APB data with one word a register.
*/
package bdc_pkg;
   // ---------------------------------------------------------------
   // Register map (byte addresses = 4 x index)
   // ---------------------------------------------------------------
   localparam logic [3:0] BDC_IDX_CONTROL = 4'h0;
   localparam logic [3:0] BDC_IDX_FLAGS = 4'h1;
   localparam logic [3:0] BDC_IDX_SCRATCH0 = 4'h2;
   localparam logic [3:0] BDC_IDX_SCRATCH1 = 4'h3;
   localparam int BDC_ADDR_W = 6;
   // ---------------------------------------------------------------
   // Control fields
   // ---------------------------------------------------------------
   localparam int BDC_CTL_BOOST = 5;
   localparam int BDC_CTL_RATE = 4;
   localparam int BDC_CTL_OSC = 3;
   localparam int BDC_CTL_MON = 2;
   localparam int BDC_CTL_UNLOCK = 1;
   localparam int BDC_CTL_DRST = 0;
   // ---------------------------------------------------------------
   // Flag fields
   // ---------------------------------------------------------------
   localparam int BDC_FLG_ABSENT = 7;
   localparam int BDC_FLG_STABLE = 3;
   localparam int BDC_FLG_FAULT = 2;
   localparam int BDC_FLG_BROWN = 1;
   localparam int BDC_FLG_INSERT = 0;
   // ---------------------------------------------------------------
   // Reset values and timing
   // ---------------------------------------------------------------
   localparam logic [7:0] BDC_CTL_RESET = 8'h00;
   localparam logic [7:0] BDC_FLG_RESET = 8'h00;
   localparam logic [7:0] BDC_SCR_RESET = 8'h00;
   localparam int BDC_MISS_SWINGS = 64;
   localparam int BDC_MISS_W = 7;
   localparam int BDC_STABLE_SWINGS = 16;
   localparam int BDC_PROTECT_WINDOW = 4;
endpackage

// ===== bdc_sticky.sv
/*
 One hardware-set, write-one-to-clear flag.
 Assumes set and clear are synchronous to pclk; set wins over clear.
*/
`timescale 1ns/1ns
`default_nettype none
module bdc_sticky
   import bdc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic set_i,
   input wire logic clr_i,
   output logic flag_r
);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_r <= 1'b0;
      end else if (set_i) begin
         flag_r <= 1'b1;
      end else if (clr_i) begin
         flag_r <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ===== bdc_top_test.sv
/*
 Self-checking testbench for the backup domain control register bank.
 Assumes the APB slave answers in its own time, bounded only by the run
 timeout, and that crystal and supply inputs are driven synchronous to pclk.
*/
`timescale 1ns/1ns
`default_nettype none
module bdc_top_test;
   import bdc_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [31:0] paddr, pwdata, prdata;
   logic [3:0] pstrb;
   logic protect_open, main_brownout, backup_supply_pin, on_backup_power;
   logic supply_brownout_detector, crystal_swing, crystal_osc_on;
   logic crystal_drive_boost, tick_rate_select, crystal_monitor_on;
   logic domain_access_unlock, domain_reset_pulse;
   logic [7:0] rd;
   int mismatches, cmp_count, cycles, pulses, p0;

   bdc_top u_bdc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .protect_open(protect_open), .main_brownout(main_brownout),
      .backup_supply_pin(backup_supply_pin),
      .on_backup_power(on_backup_power),
      .supply_brownout_detector(supply_brownout_detector),
      .crystal_swing(crystal_swing), .crystal_osc_on(crystal_osc_on),
      .crystal_drive_boost(crystal_drive_boost),
      .tick_rate_select(tick_rate_select),
      .crystal_monitor_on(crystal_monitor_on),
      .domain_access_unlock(domain_access_unlock),
      .domain_reset_pulse(domain_reset_pulse));

   // ---------------------------------------------------------------
   // Clock, timeout and reset pulse counter
   // ---------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (domain_reset_pulse === 1'b1) begin
         pulses <= pulses + 1;
      end
      if (cycles == 5000) begin
         mismatches++;
         end_of_test();
      end
   end

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One APB transfer, entered just after a clock edge
   task automatic xfer(input logic w, input logic [3:0] idx,
                       input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {26'h0, idx, 2'h0};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [3:0] idx, input logic [7:0] d);
      xfer(1'b1, idx, d);
   endtask

   task automatic chk_rd(input string nm, input logic [3:0] idx,
                         input logic [7:0] e);
      xfer(1'b0, idx, 8'h00);
      chk(nm, {24'h0, e}, {24'h0, rd});
      chk("read error", 32'h0, {31'h0, err});
   endtask

   // Boost, rate, oscillator, monitor, unlock
   task automatic outs(input logic [4:0] e);
      @(posedge pclk);
      chk("outputs", {27'h0, e}, {27'h0, crystal_drive_boost,
         tick_rate_select, crystal_osc_on, crystal_monitor_on,
         domain_access_unlock});
   endtask

   task automatic dev_reset();
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, protect_open, main_brownout} = 5'h00;
      {on_backup_power, supply_brownout_detector, crystal_swing} = 3'h0;
      backup_supply_pin = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
      pstrb = 4'hF;
      {mismatches, cmp_count, cycles, pulses} = {32'h0, 32'h0, 32'h0, 32'h0};
      dev_reset();
      outs(5'b00000);
      chk_rd("flags", BDC_IDX_FLAGS, 8'h80);
      wr(BDC_IDX_CONTROL, 8'h08);
      outs(5'b00000);
      chk_rd("locked control", BDC_IDX_CONTROL, 8'h00);
      wr(BDC_IDX_FLAGS, 8'h80);
      chk_rd("flags", BDC_IDX_FLAGS, 8'h00);
      $display("test reset_and_lock done");
      wr(BDC_IDX_CONTROL, 8'h02);
      outs(5'b00001);
      wr(BDC_IDX_CONTROL, 8'h00);
      outs(5'b00001);
      wr(BDC_IDX_SCRATCH0, 8'hA5);
      wr(BDC_IDX_SCRATCH1, 8'h5A);
      pstrb <= 4'hE;
      wr(BDC_IDX_SCRATCH1, 8'hFF);
      pstrb <= 4'hF;
      chk_rd("scratch0", BDC_IDX_SCRATCH0, 8'hA5);
      chk_rd("scratch1", BDC_IDX_SCRATCH1, 8'h5A);
      xfer(1'b0, 4'h4, 8'h00);
      chk("unmapped error", 32'h1, {31'h0, err});
      $display("test unlock_and_scratch done");
      wr(BDC_IDX_CONTROL, 8'h32);
      outs(5'b11001);
      wr(BDC_IDX_CONTROL, 8'h1A);
      outs(5'b01101);
      wr(BDC_IDX_CONTROL, 8'h02);
      outs(5'b01101);
      chk_rd("control", BDC_IDX_CONTROL, 8'h1A);
      $display("test control_fields done");
      crystal_swing <= 1'b1;
      repeat (20) @(posedge pclk);
      chk_rd("flags stable", BDC_IDX_FLAGS, 8'h08);
      wr(BDC_IDX_CONTROL, 8'h1E);
      wr(BDC_IDX_CONTROL, 8'h1A);
      outs(5'b01111);
      crystal_swing <= 1'b0;
      repeat (62) @(posedge pclk);
      chk_rd("flags no fault", BDC_IDX_FLAGS, 8'h08);
      chk_rd("flags fault", BDC_IDX_FLAGS, 8'h0C);
      crystal_swing <= 1'b1;
      wr(BDC_IDX_FLAGS, 8'h04);
      chk_rd("fault cleared", BDC_IDX_FLAGS, 8'h08);
      $display("test crystal_monitor done");
      p0 = pulses;
      wr(BDC_IDX_CONTROL, 8'h01);
      repeat (3) @(posedge pclk);
      chk("unprotected reset", p0, pulses);
      protect_open <= 1'b1;
      wr(BDC_IDX_CONTROL, 8'h09);
      repeat (3) @(posedge pclk);
      chk("blocked reset", p0, pulses);
      wr(BDC_IDX_CONTROL, 8'h01);
      repeat (3) @(posedge pclk);
      chk("reset pulses", p0 + 1, pulses);
      protect_open <= 1'b0;
      outs(5'b00001);
      chk_rd("flags after reset", BDC_IDX_FLAGS, 8'h00);
      $display("test domain_reset done");
      on_backup_power <= 1'b1;
      supply_brownout_detector <= 1'b1;
      @(posedge pclk);
      supply_brownout_detector <= 1'b0;
      on_backup_power <= 1'b0;
      chk_rd("flags brownout", BDC_IDX_FLAGS, 8'h02);
      wr(BDC_IDX_FLAGS, 8'h02);
      chk_rd("brownout cleared", BDC_IDX_FLAGS, 8'h00);
      backup_supply_pin <= 1'b1;
      repeat (5) @(posedge pclk);
      chk_rd("flags insert held", BDC_IDX_FLAGS, 8'h00);
      main_brownout <= 1'b1;
      wr(BDC_IDX_SCRATCH0, 8'h3C);
      main_brownout <= 1'b0;
      chk_rd("scratch0 kept", BDC_IDX_SCRATCH0, 8'hA5);
      $display("test supply_flags done");
      dev_reset();
      outs(5'b00000);
      chk_rd("flags insert", BDC_IDX_FLAGS, 8'h01);
      wr(BDC_IDX_CONTROL, 8'h02);
      chk_rd("scratch1 retained", BDC_IDX_SCRATCH1, 8'h5A);
      $display("test second_reset done");
      end_of_test();
   end
endmodule
`default_nettype wire
